/* File: pcicw_pkg.sv */
// shared offsets, field layouts and reset values of the configuration window
package pcicw_pkg;
  // register byte offsets
  localparam logic [7:0] off_command_status = 8'h04; // command and status word
  localparam logic [7:0] off_class_revision = 8'h08; // class and revision word
  localparam logic [7:0] off_burst_latency = 8'h0c; // latency timer and cache line size
  localparam logic [7:0] off_io_window_base = 8'h10; // i/o base address word
  // command bit positions
  localparam int bit_io_space_enable = 0; // i/o decode enable
  localparam int bit_memory_space_enable = 1; // memory decode enable
  localparam int bit_bus_master_enable = 2; // master ability enable
  localparam int bit_parity_response_enable = 6; // parity response enable
  localparam int bit_system_error_enable = 8; // address parity serr enable
  localparam int bit_parity_error_status = 31; // sticky parity error seen
  // writable command bits and reset image
  localparam logic [31:0] command_write_mask = 32'h0000_0147; // bits 8,6,2,1,0
  localparam logic [31:0] command_reset = 32'h0000_0004; // master ability on
  localparam logic [31:0] status_fixed_bits = 32'h0290_0000; // medium devsel, fast b2b, capabilities
  // class word field positions
  localparam int base_class_lsb = 24; // base class 31:24
  localparam int subclass_lsb = 16; // subclass 23:16
  localparam int revision_lsb = 4; // revision 7:4
  localparam int step_lsb = 0; // step 3:0
  // latency word field positions
  localparam int latency_timer_lsb = 8; // latency timer 15:8
  localparam int cache_line_size_lsb = 0; // cache line size 7:0
  // supported cache line sizes in double words
  localparam logic [7:0] cls_8_dw = 8'h08; // eight double words
  localparam logic [7:0] cls_16_dw = 8'h10; // sixteen double words
  localparam logic [7:0] cls_32_dw = 8'h20; // thirty-two double words
  // i/o base layout
  localparam int io_window_base_lsb = 8; // base 31:8
  localparam logic [31:0] io_window_base_mask = 32'hffff_ff00; // writable base bits
  localparam logic [31:0] io_window_base_reset = 32'h0000_0001; // reset image
  localparam logic [31:0] io_space_flag = 32'h0000_0001; // bit 0 reads one
  // latency counter states
  typedef enum logic [2:0] {
    pcicw_lat_idle = 3'b001,
    pcicw_lat_count = 3'b010,
    pcicw_lat_expired = 3'b100
  } pcicw_lat_state_t;
endpackage

/* File: pcicw_latency_timer.sv */
`timescale 1ns/1ps
// master latency counter: loads on frame start, ends burst once expired and grant goes
module pcicw_latency_timer #(
  parameter int width = 8 // counter width
) (
  input wire logic clock, // pci clock
  input wire logic reset, // synchronous reset, active high
  input wire logic [width-1:0] latency_value, // programmed latency in clocks
  input wire logic frame_active, // our master drives frame
  input wire logic grant_present, // synchronised grant still given
  output logic expired, // count has run out in this frame
  output logic master_terminate // end data phase now
);
  pcicw_pkg::pcicw_lat_state_t state; // counter state
  pcicw_pkg::pcicw_lat_state_t next_state; // next counter state
  logic [width-1:0] count; // cycles left
  logic [width-1:0] next_count; // next cycles left
  logic frame_last; // frame seen last cycle
  logic next_frame_last; // next frame history

  // next state of the counter
  always_comb begin
    next_state = state;
    next_count = count;
    next_frame_last = frame_active;
    case (state)
      pcicw_pkg::pcicw_lat_idle: begin
        // count starts when frame is asserted
        if (frame_active && !frame_last) begin // RQ8
          next_count = latency_value;
          next_state = (latency_value == '0) ? pcicw_pkg::pcicw_lat_expired : pcicw_pkg::pcicw_lat_count;
        end
      end
      pcicw_pkg::pcicw_lat_count: begin
        if (!frame_active) begin
          next_state = pcicw_pkg::pcicw_lat_idle;
        end else if (count <= width'(1)) begin // RQ8
          next_count = '0;
          next_state = pcicw_pkg::pcicw_lat_expired;
        end else begin
          next_count = count - width'(1);
        end
      end
      pcicw_pkg::pcicw_lat_expired: begin
        // wait for frame to drop
        if (!frame_active) begin
          next_state = pcicw_pkg::pcicw_lat_idle;
        end
      end
      default: begin
        next_state = pcicw_pkg::pcicw_lat_idle;
        next_count = '0;
      end
    endcase
  end

  // register the counter
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= pcicw_pkg::pcicw_lat_idle;
      count <= '0;
      frame_last <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      frame_last <= next_frame_last;
    end
  end

  // terminate once expired, frame still held and grant removed
  assign expired = (state == pcicw_pkg::pcicw_lat_expired);
  assign master_terminate = expired && frame_active && !grant_present; // RQ9
endmodule

/* File: pcicw_config_window.sv */
`timescale 1ns/1ps
// Functional notes
// [RQ1] parity response off: parity errors ignored; the code still sets the sticky parity status bit 31
// [RQ2] parity response on: flag system error bit
// [RQ3] command bit 2 gates bus mastering
// [RQ4] command bit 1 gates memory decode
// [RQ5] command bit 0 gates i/o decode
// [RQ6] class word: network base, ethernet subclass
// [RQ7] read-only revision and step fields
// [RQ8] writable latency timer, counts from frame
// [RQ9] expired timer ends burst when grant leaves
// [RQ10] writable cache line size, 8/16/32 only
// [RQ11] software copies line size into bus mode
// [RQ12] writable i/o base bits, reserved low bits
// [RQ13] i/o flag reads one, resets 00000001
// [RQ14] read-only bits ignore writes, reserved zero
module pcicw_config_window #(
  parameter logic [7:0] base_class_value = 8'h02, // network controller
  parameter logic [7:0] subclass_value = 8'h00, // ethernet controller
  parameter logic [3:0] revision_value = 4'h0, // arbitrary revision
  parameter logic [3:0] step_value = 4'h1, // arbitrary step
  parameter int latency_width = 8 // latency timer width
) (
  input wire logic clock, // pci clock
  input wire logic reset, // synchronous reset, active high
  input wire logic cfg_write, // configuration write strobe
  input wire logic cfg_read, // configuration read strobe
  input wire logic [7:0] cfg_addr, // configuration byte offset
  input wire logic [3:0] cfg_byte_en, // byte enables, active high
  input wire logic [31:0] cfg_wdata, // write data
  output logic [31:0] cfg_rdata, // read data, registered
  output logic cfg_rvalid, // read data valid pulse
  input wire logic parity_error_detected, // parity error pulse from bus logic
  output logic system_error_set, // pulse to set host status bit 13
  output logic system_error_response, // address parity serr enable
  input wire logic master_request, // core wants the bus
  output logic master_request_gated, // request allowed onto the bus
  input wire logic mem_cycle, // memory cycle addressed at us
  output logic mem_claim, // claim the memory cycle
  input wire logic io_cycle, // i/o cycle seen on the bus
  input wire logic [31:0] io_address, // i/o cycle address
  output logic io_claim, // claim the i/o cycle
  input wire logic frame_active, // our master drives frame
  input wire logic gnt_n_pin, // grant pin, active low
  output logic master_terminate, // end master data transfer
  output logic latency_expired, // latency count has run out
  output logic [7:0] cache_line_size, // programmed line size
  output logic [23:0] io_window_base // decoded i/o base 31:8
);
  logic [31:0] command_status_cfg; // command bits and sticky status
  logic [31:0] next_command_status_cfg; // next command word
  logic [31:0] burst_latency_cfg; // latency and line size
  logic [31:0] next_burst_latency_cfg; // next latency word
  logic [31:0] io_window_base_reg; // i/o base word
  logic [31:0] next_io_window_base_reg; // next i/o base word
  logic [31:0] next_cfg_rdata; // next read data
  logic next_cfg_rvalid; // next read valid
  logic next_system_error_set; // next system error pulse
  logic [31:0] class_revision_id; // constant class word
  logic gnt_n_meta; // grant synchroniser first stage
  logic gnt_n_sync; // grant synchroniser second stage
  logic [31:0] byte_mask; // write lanes as bit mask
  // storage overview
  // - command word keeps five enable bits and the sticky parity flag
  // - latency word keeps the timer byte and a checked line size
  // - i/o base word keeps address bits 31:8 and the space flag loaded at reset
  // - class word is wired from parameters and never stored
  // - read-only and reserved bits are masked on the way in
  // - fixed status bits are ored in on the way out

  // expand byte enables into a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // merge write data into writable bits of selected lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [31:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  // line size accepted only for supported values, else cleared
  function automatic logic [7:0] legal_cls(input logic [7:0] value);
    if (value == pcicw_pkg::cls_8_dw || value == pcicw_pkg::cls_16_dw || value == pcicw_pkg::cls_32_dw) begin
      legal_cls = value; // RQ10
    end else begin
      legal_cls = 8'h00; // RQ10
    end
  endfunction

  // constant class and revision word
  assign class_revision_id = (32'(base_class_value) << pcicw_pkg::base_class_lsb) // RQ6
                           | (32'(subclass_value) << pcicw_pkg::subclass_lsb) // RQ6
                           | (32'(revision_value) << pcicw_pkg::revision_lsb) // RQ7
                           | (32'(step_value) << pcicw_pkg::step_lsb); // RQ7
  assign byte_mask = lanes(cfg_byte_en);

  // write path notes
  // - a write lands at the edge that samples the strobe
  // - a read in the next cycle already sees the new value
  // - lanes without a byte enable keep their old contents
  // - writes to the class word or unmapped offsets are dropped
  // - a parity event in the same cycle as a clear leaves the flag set
  // - the system error pulse is only raised with parity response on

  // next values of the writable registers and status
  always_comb begin
    next_command_status_cfg = command_status_cfg;
    next_burst_latency_cfg = burst_latency_cfg;
    next_io_window_base_reg = io_window_base_reg;
    next_system_error_set = 1'b0;
    if (cfg_write) begin
      case (cfg_addr)
        pcicw_pkg::off_command_status: begin
          // writable command bits only
          next_command_status_cfg = merge(command_status_cfg, cfg_wdata,
                                          byte_mask & pcicw_pkg::command_write_mask); // RQ14
          // writing one clears the sticky parity status
          if (byte_mask[pcicw_pkg::bit_parity_error_status] && cfg_wdata[pcicw_pkg::bit_parity_error_status]) begin
            next_command_status_cfg[pcicw_pkg::bit_parity_error_status] = 1'b0;
          end
        end
        pcicw_pkg::off_burst_latency: begin
          // latency timer byte
          if (cfg_byte_en[1]) begin
            next_burst_latency_cfg[pcicw_pkg::latency_timer_lsb +: 8] =
              cfg_wdata[pcicw_pkg::latency_timer_lsb +: 8]; // RQ8
          end
          // cache line size byte
          if (cfg_byte_en[0]) begin
            next_burst_latency_cfg[pcicw_pkg::cache_line_size_lsb +: 8] =
              legal_cls(cfg_wdata[pcicw_pkg::cache_line_size_lsb +: 8]); // RQ10
          end
        end
        pcicw_pkg::off_io_window_base: begin
          // base bits only, flag and reserved stay
          next_io_window_base_reg = merge(io_window_base_reg, cfg_wdata,
                                          byte_mask & pcicw_pkg::io_window_base_mask); // RQ12
        end
        default: begin
          // class word and unmapped offsets ignore writes
          next_io_window_base_reg = io_window_base_reg; // RQ14
        end
      endcase
    end
    // parity error always noted; set wins over a clear
    if (parity_error_detected) begin
      next_command_status_cfg[pcicw_pkg::bit_parity_error_status] = 1'b1;
      // system error only with parity response on
      next_system_error_set = command_status_cfg[pcicw_pkg::bit_parity_response_enable]; // RQ1 RQ2
    end
  end

  // read path notes
  // - the answer is registered and stands for one cycle only
  // - valid follows every read strobe, mapped or not
  // - unmapped offsets and idle cycles return zero data
  // - the i/o space flag is forced to one here, on top of the stored reset image
  // - the line size field never holds an unsupported value
  // - a read and a write in one cycle are served independently
  // next read data, reserved bits zero
  always_comb begin
    next_cfg_rvalid = cfg_read;
    next_cfg_rdata = 32'h0000_0000;
    if (cfg_read) begin
      case (cfg_addr)
        pcicw_pkg::off_command_status: begin
          next_cfg_rdata = command_status_cfg | pcicw_pkg::status_fixed_bits;
        end
        pcicw_pkg::off_class_revision: begin
          next_cfg_rdata = class_revision_id; // RQ6 RQ7
        end
        pcicw_pkg::off_burst_latency: begin
          next_cfg_rdata = burst_latency_cfg; // RQ14
        end
        pcicw_pkg::off_io_window_base: begin
          next_cfg_rdata = io_window_base_reg | pcicw_pkg::io_space_flag; // RQ13
        end
        default: begin
          next_cfg_rdata = 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end
  end

  // reset notes
  // - reset is synchronous and needs one clock edge
  // - bus mastering comes up enabled, all other enables off
  // - parity response starts off, so parity events are only noted
  // - latency timer and line size start at zero
  // - the i/o base word starts with only the space flag set
  // - the read port and the error pulse start quiet
  // register bank and read port
  always_ff @(posedge clock) begin
    if (reset) begin
      command_status_cfg <= pcicw_pkg::command_reset; // RQ1 RQ3
      burst_latency_cfg <= 32'h0000_0000;
      io_window_base_reg <= pcicw_pkg::io_window_base_reset; // RQ13
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
      system_error_set <= 1'b0;
    end else begin
      command_status_cfg <= next_command_status_cfg;
      burst_latency_cfg <= next_burst_latency_cfg;
      io_window_base_reg <= next_io_window_base_reg;
      cfg_rdata <= next_cfg_rdata;
      cfg_rvalid <= next_cfg_rvalid;
      system_error_set <= next_system_error_set;
    end
  end

  // the grant pin comes from the arbiter and is not related to our
  // clock edge, so it passes two flops before anything reads it
  // - both stages reset to the not-granted level
  // - only the second stage feeds the latency timer
  // - grant loss is therefore seen two clocks late
  // grant pin synchroniser
  always_ff @(posedge clock) begin
    if (reset) begin
      gnt_n_meta <= 1'b1;
      gnt_n_sync <= 1'b1;
    end else begin
      gnt_n_meta <= gnt_n_pin;
      gnt_n_sync <= gnt_n_meta;
    end
  end

  // decode gating
  // - claims and the gated request are combinational so that they
  //   follow the bus cycle without a wait state
  // - clearing an enable takes effect on the next cycle
  // - an i/o claim also needs the upper address bits to match
  // - the low eight address bits select a register inside the window
  // - the memory claim relies on the bus logic for address match
  // enables steer master request and target decode
  assign master_request_gated = master_request && command_status_cfg[pcicw_pkg::bit_bus_master_enable]; // RQ3
  assign mem_claim = mem_cycle && command_status_cfg[pcicw_pkg::bit_memory_space_enable]; // RQ4
  assign io_claim = io_cycle && command_status_cfg[pcicw_pkg::bit_io_space_enable] // RQ5
                 && (io_address[31:pcicw_pkg::io_window_base_lsb] ==
                     io_window_base_reg[31:pcicw_pkg::io_window_base_lsb]); // RQ12
  assign system_error_response = command_status_cfg[pcicw_pkg::bit_system_error_enable];
  assign cache_line_size = burst_latency_cfg[pcicw_pkg::cache_line_size_lsb +: 8];
  assign io_window_base = io_window_base_reg[31:pcicw_pkg::io_window_base_lsb];

  // latency notes
  // - the timer reloads on each rising edge of our frame
  // - a zero timer value expires at once
  // - expiry alone never ends a burst; grant must be gone too
  // - expiry clears when our frame drops
  // - a latency_width above eight would reach into reserved bits
  // latency counter for our own bursts
  pcicw_latency_timer #(
    .width(latency_width)
  ) u_latency (
    .clock(clock),
    .reset(reset),
    .latency_value(burst_latency_cfg[pcicw_pkg::latency_timer_lsb +: latency_width]),
    .frame_active(frame_active),
    .grant_present(!gnt_n_sync),
    .expired(latency_expired),
    .master_terminate(master_terminate)
  );
endmodule

/* File: pcicw_config_window_chk.sv */
`timescale 1ns/1ps
// port-level checks on the configuration window
module pcicw_config_window_chk (
  input wire logic clock, // pci clock
  input wire logic reset, // sync reset
  input wire logic cfg_read, // read strobe
  input wire logic [31:0] cfg_rdata, // read data
  input wire logic cfg_rvalid, // read valid
  input wire logic parity_error_detected, // parity pulse
  input wire logic system_error_set, // serr pulse
  input wire logic master_request, // core request
  input wire logic master_request_gated, // gated request
  input wire logic mem_cycle, // memory cycle
  input wire logic mem_claim, // memory claim
  input wire logic io_cycle, // i/o cycle
  input wire logic [31:0] io_address, // i/o address
  input wire logic io_claim, // i/o claim
  input wire logic [23:0] io_window_base, // i/o base
  input wire logic frame_active, // frame driven
  input wire logic master_terminate, // end burst
  input wire logic latency_expired, // count ran out
  input wire logic [7:0] cache_line_size // line size
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // a read strobe is answered in the next cycle
  sequence s_read_answer;
    cfg_read ##1 cfg_rvalid;
  endsequence
  read_answer_a: assert property (cfg_read |-> s_read_answer) else $error("read not answered");
  stray_valid_a: assert property (!cfg_read |=> !cfg_rvalid) else $error("valid without read");
  rdata_quiet_a: assert property (!cfg_rvalid |-> cfg_rdata == 32'h0) else $error("data off read");
  serr_cause_a: assert property (system_error_set |-> $past(parity_error_detected))
    else $error("serr without parity");
  master_gate_a: assert property (master_request_gated |-> master_request) else $error("stray request");
  mem_gate_a: assert property (mem_claim |-> mem_cycle) else $error("stray memory claim");
  io_match_a: assert property (io_claim |-> io_cycle && io_address[31:8] == io_window_base)
    else $error("bad i/o claim");
  term_cause_a: assert property (master_terminate |-> latency_expired && frame_active)
    else $error("early terminate");
  expire_drop_a: assert property ($fell(frame_active) |-> ##[0:2] !latency_expired)
    else $error("expiry held");
  cls_legal_a: assert property (cache_line_size inside {8'h00, 8'h08, 8'h10, 8'h20})
    else $error("bad line size");
endmodule

/* File: pcicw_arbiter_model.sv */
`timescale 1ns/1ps
// arbiter stand-in: grants a let-out request, withdraws on command
module pcicw_arbiter_model (
  input wire logic clock, // pci clock
  input wire logic reset, // sync reset
  input wire logic bus_request, // gated request
  input wire logic withdraw, // take the grant away
  output logic gnt_n_pin // grant, active low
);
  logic next_gnt_n; // next grant level
  // grant only while asked and not withdrawn
  always_comb begin
    next_gnt_n = !(bus_request && !withdraw);
  end
  // grant register, idle not granted
  always_ff @(posedge clock) begin
    if (reset) begin
      gnt_n_pin <= 1'b1;
    end else begin
      gnt_n_pin <= next_gnt_n;
    end
  end
endmodule

/* File: test_pci_config_command_window.sv */
`timescale 1ns/1ps
module test_pci_config_command_window;
  logic clock, reset, cfg_write, cfg_read, cfg_rvalid, parity_error_detected, system_error_set; // control
  logic system_error_response, master_request, master_request_gated, mem_cycle, mem_claim; // gating
  logic io_cycle, io_claim, frame_active, gnt_n_pin, master_terminate, latency_expired, withdraw; // bus side
  logic [7:0] cfg_addr, cache_line_size; // offset and line size
  logic [3:0] cfg_byte_en; // lanes
  logic [31:0] cfg_wdata, cfg_rdata, io_address, seed, d; // data
  logic [23:0] io_window_base; // base out
  int n_mismatch, checked, k; // counters
  pcicw_config_window u_pcicw_config_window (.clock(clock), .reset(reset), .cfg_write(cfg_write),
    .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .parity_error_detected(parity_error_detected),
    .system_error_set(system_error_set), .system_error_response(system_error_response),
    .master_request(master_request), .master_request_gated(master_request_gated), .mem_cycle(mem_cycle),
    .mem_claim(mem_claim), .io_cycle(io_cycle), .io_address(io_address), .io_claim(io_claim),
    .frame_active(frame_active), .gnt_n_pin(gnt_n_pin), .master_terminate(master_terminate),
    .latency_expired(latency_expired), .cache_line_size(cache_line_size), .io_window_base(io_window_base));
  pcicw_arbiter_model u_pcicw_arbiter_model (.clock(clock), .reset(reset), .bus_request(master_request_gated),
    .withdraw(withdraw), .gnt_n_pin(gnt_n_pin));
  // 250 mhz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // stored line size: unsupported values read zero
  function automatic logic [7:0] exp_cls(input logic [7:0] v);
    return (v == 8'h08 || v == 8'h10 || v == 8'h20) ? v : 8'h00;
  endfunction
  // compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] dat);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_addr <= a;
    cfg_byte_en <= be;
    cfg_wdata <= dat;
    @(posedge clock);
    cfg_write <= 1'b0;
  endtask
  // one-cycle read strobe, answer seen in the next cycle
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    cfg_read <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_read <= 1'b0;
    #1 chk("rvalid", 32'(cfg_rvalid), 32'h1);
    chk("rdata", cfg_rdata, exp);
  endtask
  // drive all decode inputs, check claims follow the command bits
  task gate(input logic on);
    @(posedge clock);
    master_request <= 1'b1;
    mem_cycle <= 1'b1;
    io_cycle <= 1'b1;
    io_address <= {io_window_base, 8'h5a};
    #1 chk("req_gated", 32'(master_request_gated), 32'(on));
    chk("mem_claim", 32'(mem_claim), 32'(on));
    chk("io_claim", 32'(io_claim), 32'(on));
    @(posedge clock);
    io_address <= {io_window_base + 24'h1, 8'h5a};
    #1 chk("io_miss", 32'(io_claim), 32'h0);
    @(posedge clock);
    {master_request, mem_cycle, io_cycle} <= 3'b000;
  endtask
  // counts, verdict, end of run
  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {cfg_write, cfg_read, parity_error_detected, master_request, mem_cycle, io_cycle} = 6'h0;
    {frame_active, withdraw, cfg_addr, cfg_byte_en, cfg_wdata, io_address} = '0;
    reset = 1'b1;
    seed = 32'haab4;
    n_mismatch = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    // reset images, unmapped place, read-only class word
    rd(8'h04, pcicw_pkg::command_reset | pcicw_pkg::status_fixed_bits);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h0000_0001);
    rd(8'h20, 32'h0);
    wr(8'h08, 4'hf, 32'hffff_ffff);
    rd(8'h08, 32'h0200_0001);
    // random words, first four line sizes 8, 16, 32 and unsupported 64
    for (k = 0; k < 12; k++) begin
      seed = xs(seed);
      d = seed;
      if (k < 4) d[7:0] = 8'h08 << k;
      wr(8'h04, 4'hf, d);
      rd(8'h04, (d & pcicw_pkg::command_write_mask) | pcicw_pkg::status_fixed_bits);
      chk("serr_resp", 32'(system_error_response), 32'(d[8]));
      wr(8'h0c, 4'hf, d);
      rd(8'h0c, {16'h0, d[15:8], exp_cls(d[7:0])});
      chk("cls_out", 32'(cache_line_size), 32'(exp_cls(d[7:0])));
      wr(8'h10, 4'hf, d);
      rd(8'h10, (d & pcicw_pkg::io_window_base_mask) | pcicw_pkg::io_space_flag);
      chk("io_base", 32'(io_window_base), 32'(d[31:8]));
    end
    wr(8'h10, 4'h1, 32'hffff_ffff);
    rd(8'h10, (d & pcicw_pkg::io_window_base_mask) | pcicw_pkg::io_space_flag);
    // decode gating off, then on
    wr(8'h04, 4'hf, 32'h0);
    gate(1'b0);
    wr(8'h04, 4'hf, 32'h7);
    gate(1'b1);
    // parity error with response off then on; sticky bit cleared by writing one
    for (k = 0; k < 2; k++) begin
      wr(8'h04, 4'hf, 32'h7 | (32'(k) << 6));
      @(posedge clock);
      parity_error_detected <= 1'b1;
      @(posedge clock);
      parity_error_detected <= 1'b0;
      #1 chk("serr_set", 32'(system_error_set), 32'(k));
      rd(8'h04, 32'h8290_0007 | (32'(k) << 6));
      wr(8'h04, 4'h8, 32'h8000_0000);
      rd(8'h04, 32'h0290_0007 | (32'(k) << 6));
    end
    // latency of four clocks, then grant withdrawn
    wr(8'h0c, 4'h2, 32'h0000_0400);
    @(posedge clock);
    master_request <= 1'b1;
    repeat (4) @(posedge clock);
    frame_active <= 1'b1;
    for (k = 0; k < 20 && latency_expired !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk("expiry", 32'(k), 32'(4 + 1));
    chk("no_term", 32'(master_terminate), 32'h0);
    @(posedge clock);
    withdraw <= 1'b1;
    for (k = 0; k < 8 && master_terminate !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk("terminate", 32'(master_terminate), 32'h1);
    @(posedge clock);
    {frame_active, master_request, withdraw} <= 3'b000;
    repeat (3) @(posedge clock);
    #1 chk("expiry_clear", 32'(latency_expired), 32'h0);
    report_and_stop;
  end
endmodule
bind pcicw_config_window pcicw_config_window_chk u_pcicw_config_window_chk (.clock(clock), .reset(reset),
  .cfg_read(cfg_read), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .master_request(master_request),
  .parity_error_detected(parity_error_detected), .system_error_set(system_error_set),
  .master_request_gated(master_request_gated), .mem_cycle(mem_cycle), .mem_claim(mem_claim),
  .io_cycle(io_cycle), .io_address(io_address), .io_claim(io_claim), .io_window_base(io_window_base),
  .frame_active(frame_active), .master_terminate(master_terminate), .latency_expired(latency_expired),
  .cache_line_size(cache_line_size));
